// *** verilog/ims_pkg.sv ***
`default_nettype none

// ----------------------------------------------------------------------------
// Shared constants of the serial memory-access slave
// ----------------------------------------------------------------------------
package ims_pkg;

    // Memory geometry.
    localparam int          ADDR_W          = 11;
    localparam int          MEM_DEPTH       = 2048;
    localparam int          PAGE_BITS       = 4;
    localparam logic [10:0] ADDR_WIPER      = 11'h7ff;
    localparam logic [10:0] ADDR_VOL_CTRL   = 11'h7fe;
    localparam int          VOL_ONLY_BIT    = 7;

    // Reset values.
    localparam logic [6:0]  WIPER_RESET     = 7'h40;

    // Arbitrary device-type code; the value carries no meaning.
    localparam logic [3:0]  TYPE_CODE_DEF   = 4'h5;

    // Bit counter positions within a nine-clock byte slot.
    localparam logic [3:0]  BIT_LAST        = 4'h8;
    localparam logic [3:0]  BIT_ACK         = 4'h9;

    // Timing.
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          NV_WRITE_NS     = 5000000;
    localparam int          PWRUP_NS        = 1000000;
    localparam int          NV_WRITE_CYC    = NV_WRITE_NS / CLK_PERIOD_NS;
    localparam int          PWRUP_CYC       = PWRUP_NS / CLK_PERIOD_NS;

    // Link-side protocol states.
    typedef enum logic [2:0]
    {
        IMS_IDLE,
        IMS_ID,
        IMS_ADDR,
        IMS_WDATA,
        IMS_RDATA
    } ims_link_e;

endpackage : ims_pkg

`default_nettype wire

// *** verilog/ims_ctl_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Crossing signals between the link logic and the core timer
// ----------------------------------------------------------------------------
interface ims_ctl_if;

    logic nv_req_tgl;   // Toggles once per nonvolatile write request.
    logic nv_ack_tgl;   // Echoes the request toggle when the cycle ends.
    logic pwr_ready;    // High once the power-up sequence has finished.

    modport core
    (
        input  nv_req_tgl,
        output nv_ack_tgl,
        output pwr_ready
    );

    modport link
    (
        output nv_req_tgl,
        input  nv_ack_tgl,
        input  pwr_ready
    );

endinterface : ims_ctl_if

`default_nettype wire

// *** verilog/ims_nv_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Power-up and self-timed nonvolatile write timer on the system clock
// ----------------------------------------------------------------------------
module ims_nv_timer
    import ims_pkg::*;
#(
    parameter int NV_CYCLES = NV_WRITE_CYC,
    parameter int PU_CYCLES = PWRUP_CYC
)
(
    // Clock and synchronised reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Crossing to the link logic.
    ims_ctl_if.core   ctl
);

    logic        req_m;
    logic        req_s;
    logic        ack_tgl;
    logic        ready;
    logic [31:0] nv_cnt;
    logic [31:0] pu_cnt;
    wire  logic  busy    = req_s != ack_tgl;
    wire  logic  nv_done = busy && (nv_cnt == 32'(NV_CYCLES - 1));
    wire  logic  pu_done = pu_cnt == 32'(PU_CYCLES - 1);

    assign ctl.nv_ack_tgl = ack_tgl;
    assign ctl.pwr_ready  = ready;

    // Two flip-flops carry the request toggle into this domain.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_m <= 1'b0;
            req_s <= 1'b0;
        end
        else
        begin
            req_m <= ctl.nv_req_tgl;
            req_s <= req_m;
        end
    end

    // A pending request runs the full write time, then the toggle is echoed.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nv_cnt  <= 32'h0000_0000;
            ack_tgl <= 1'b0;
        end
        else if (nv_done)
        begin
            nv_cnt  <= 32'h0000_0000;
            ack_tgl <= req_s;
        end
        else if (busy)
        begin
            nv_cnt  <= nv_cnt + 32'h0000_0001;
        end
    end

    // The power-up sequence holds the link off for a fixed time after reset.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pu_cnt <= 32'h0000_0000;
            ready  <= 1'b0;
        end
        else if (!ready)
        begin
            pu_cnt <= pu_cnt + 32'h0000_0001;
            ready  <= pu_done;
        end
    end

endmodule : ims_nv_timer

`default_nettype wire

// *** verilog/ims_i2c_slave.sv ***
// Overview of operation
// - Bytes shift most significant bit first.
// - Data changes only while clock low.
// - Start is data falling, clock high.
// - Stop is data rising, clock high.
// - Nothing answered before a start.
// - Data pin released after power-up.
// - Starts ignored during power-up or writes.
// - Read or volatile-only stop returns idle.
// - Nonvolatile write stop launches timed cycle.
// - Bus ignored, pin released while writing.
// - Release after eight bits, receiver acknowledges.
// - Acknowledge identification, address, write data.
// - Identification holds type code, address bits.
// - Identification LSB: one read, zero write.
// - Address is eleven bits, three plus eight.
// - Write bytes go to consecutive addresses.
// - Pages of sixteen bytes, low four vary.
// - Protect pin low: no store, no acknowledge.
// - Top address loads wiper on LSB fall.
// - Keep sending while master acknowledges.
// - Read pointer loaded, advances per byte.
// - Top read picks wiper or stored value.
// - Top write updates wiper, maybe stored value.
// - Volatile-only bit is 7FE MSB, reset zero.
`timescale 1ns/1ps
`default_nettype none

module ims_i2c_slave
    import ims_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = TYPE_CODE_DEF,
    parameter int         NV_CYCLES = NV_WRITE_CYC,
    parameter int         PU_CYCLES = PWRUP_CYC
)
(
    // System clock and reset.
    input  wire logic       clk,
    input  wire logic       nrst,
    // Sampling clock of the link logic.
    input  wire logic       link_clk,
    // Serial bus pins.
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe,
    // Write-protect pin.
    input  wire logic       write_protect_n,
    // Wiper and status.
    output var  logic [6:0] wiper_position_register,
    output var  logic       nv_write_busy
);

    // ------------------------------------------------------------------------
    // Resets
    // ------------------------------------------------------------------------

    logic rst_m;
    logic rst_n;
    logic lrst_m;
    logic lrst_n;

    // Reset is released through two flip-flops in each domain.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lrst_m <= 1'b0;
            lrst_n <= 1'b0;
        end
        else
        begin
            lrst_m <= 1'b1;
            lrst_n <= lrst_m;
        end
    end

    // ------------------------------------------------------------------------
    // Core timer
    // ------------------------------------------------------------------------

    ims_ctl_if ctl ();

    ims_nv_timer
    #(
        .NV_CYCLES (NV_CYCLES),
        .PU_CYCLES (PU_CYCLES)
    )
    u_timer
    (
        .clk   (clk),
        .rst_n (rst_n),
        .ctl   (ctl)
    );

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------

    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic wp_m;
    logic wp_s;
    logic ack_m;
    logic ack_s;
    logic rdy_m;
    logic rdy_s;
    logic rdy_d;

    // Every pin and every core signal passes two flip-flops; the delayed
    // copies only ever look at the second stage.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            {wp_m, wp_s}          <= 2'h0;
            {ack_m, ack_s}        <= 2'h0;
            {rdy_m, rdy_s, rdy_d} <= 3'h0;
        end
        else
        begin
            {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
            {wp_m, wp_s}          <= {write_protect_n, wp_m};
            {ack_m, ack_s}        <= {ctl.nv_ack_tgl, ack_m};
            {rdy_m, rdy_s, rdy_d} <= {ctl.pwr_ready, rdy_m, rdy_s};
        end
    end

    // ------------------------------------------------------------------------
    // Bus event decode
    // ------------------------------------------------------------------------

    ims_link_e   state;
    ims_link_e   next_state;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic [10:0] ptr;
    logic        macked;
    logic        nv_pending;
    logic        req_tgl;
    logic        vol_only;
    logic [6:0]  stored_initial_wiper_value;
    logic [7:0]  mem [0:MEM_DEPTH-1];

    // Data edges while the clock stays high mark start and stop.
    wire logic start_det = scl_s && scl_d && sda_d && !sda_s;
    wire logic stop_det  = scl_s && scl_d && !sda_d && sda_s;
    wire logic scl_rise  = scl_s && !scl_d;
    wire logic scl_fall  = !scl_s && scl_d;

    // A write cycle is pending from the request toggle until its echo, so a
    // start arriving before the core has even seen the request is ignored too.
    wire logic nv_busy   = (req_tgl != ack_s) || !rdy_s;

    wire logic active    = state != IMS_IDLE;
    wire logic rx_state  = (state == IMS_ID) || (state == IMS_ADDR) || (state == IMS_WDATA);
    wire logic ev_bit    = active && scl_rise && (cnt < BIT_LAST);
    wire logic ev_byte   = active && scl_fall && (cnt == BIT_LAST);
    wire logic ev_ackend = active && scl_fall && (cnt == BIT_ACK);
    wire logic tx_shift  = (state == IMS_RDATA) && scl_fall && (cnt != 4'h0) && (cnt < BIT_LAST);

    // Identification byte: type code, three address bits, direction.
    wire logic id_match  = shift[7:4] == TYPE_CODE;
    wire logic id_read   = shift[0];

    // The device answers identification, address and permitted write data.
    wire logic ack_now   = ((state == IMS_ID) && id_match) || (state == IMS_ADDR) ||
                           ((state == IMS_WDATA) && wp_s);

    // ------------------------------------------------------------------------
    // Address decode and read data
    // ------------------------------------------------------------------------

    // Classifies an address; used for both the read mux and the write path.
    function automatic logic [1:0] addr_kind(input logic [10:0] a);
        begin
            addr_kind = (a == ADDR_WIPER) ? 2'h2 : (a == ADDR_VOL_CTRL) ? 2'h1 : 2'h0;
        end
    endfunction : addr_kind

    wire logic [1:0] ptr_kind  = addr_kind(ptr);
    wire logic [6:0] top_value = vol_only ? wiper_position_register : stored_initial_wiper_value;
    wire logic [7:0] rd_data   = (ptr_kind == 2'h2) ? {1'b0, top_value} :
                                 (ptr_kind == 2'h1) ? {vol_only, 7'h00} : mem[ptr];

    // Accepted write data byte and its destination.
    wire logic wr_ev     = ev_byte && (state == IMS_WDATA) && wp_s;
    wire logic wr_mem    = wr_ev && (ptr_kind == 2'h0);
    wire logic wr_top    = wr_ev && (ptr_kind == 2'h2);
    wire logic wr_ctrl   = wr_ev && (ptr_kind == 2'h1);
    wire logic wr_nv     = wr_mem || (wr_top && !vol_only);

    // Page-limited increment: only the low four bits roll over.
    wire logic [10:0] ptr_page = {ptr[10:PAGE_BITS], ptr[PAGE_BITS-1:0] + 4'h1};

    // ------------------------------------------------------------------------
    // Protocol state machine
    // ------------------------------------------------------------------------

    // While a write cycle or the power-up sequence runs the bus is not watched at all; otherwise start
    // always restarts the frame and stop always ends it.
    always_comb
    begin
        next_state = state;
        if (nv_busy)
            next_state = IMS_IDLE;
        else if (start_det)
            next_state = IMS_ID;
        else if (stop_det)
            next_state = IMS_IDLE;
        else
        begin
            case (state)
                IMS_ID:
                    if (ev_byte)
                        next_state = !id_match ? IMS_IDLE : id_read ? IMS_RDATA : IMS_ADDR;
                IMS_ADDR:
                    if (ev_byte)
                        next_state = IMS_WDATA;
                IMS_WDATA:
                    if (ev_byte && !wp_s)
                        next_state = IMS_IDLE;
                IMS_RDATA:
                    if (ev_ackend && !macked)
                        next_state = IMS_IDLE;
                default:
                    next_state = state;
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            state <= IMS_IDLE;
        else
            state <= next_state;
    end

    // Bit counter: 0..7 data bits, 8 after the last rising edge, 9 in the
    // acknowledge clock.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            cnt <= 4'h0;
        else if (nv_busy || start_det || !active)
            cnt <= 4'h0;
        else if (ev_bit)
            cnt <= cnt + 4'h1;
        else if (ev_byte)
            cnt <= BIT_ACK;
        else if (ev_ackend)
            cnt <= 4'h0;
    end

    // Shift register, most significant bit first both ways.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            shift <= 8'h00;
        else if (ev_bit && rx_state)
            shift <= {shift[6:0], sda_s};
        else if (ev_ackend && (state == IMS_RDATA) && macked)
            shift <= rd_data;
        else if (tx_shift)
            shift <= {shift[6:0], 1'b0};
    end

    // ------------------------------------------------------------------------
    // Data pin drive
    // ------------------------------------------------------------------------

    // The pin is only pulled on a clock falling edge, so data is never pulled while
    // the clock is high; it is released on every start, stop and write cycle.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            sda_oe <= 1'b0;
        else if (nv_busy || start_det || stop_det || !active)
            sda_oe <= 1'b0;
        else if (ev_byte)
            sda_oe <= ack_now && (state != IMS_RDATA);
        else if (ev_ackend)
            sda_oe <= (state == IMS_RDATA) && macked && !rd_data[7];
        else if (tx_shift)
            sda_oe <= !shift[6];
    end

    // Open-drain: the pin is only ever pulled low.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            sda_o <= 1'b0;
        else
            sda_o <= 1'b0;
    end

    // Master acknowledge: sampled on the rising edge of the ninth clock.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            macked <= 1'b0;
        else if (ev_byte && (state == IMS_ID))
            macked <= 1'b1;
        else if ((state == IMS_RDATA) && scl_rise && (cnt == BIT_ACK))
            macked <= !sda_s;
    end

    // ------------------------------------------------------------------------
    // Address pointer
    // ------------------------------------------------------------------------

    // The identification byte sets the upper three bits and keeps the lower
    // eight, so the repeated start of a read reuses the written address.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            ptr <= 11'h000;
        else if (ev_byte && (state == IMS_ID) && id_match)
            ptr <= {shift[3:1], ptr[7:0]};
        else if (ev_byte && (state == IMS_ADDR))
            ptr <= {ptr[10:8], shift};
        else if (wr_ev)
            ptr <= ptr_page;
        else if (ev_byte && (state == IMS_RDATA))
            ptr <= ptr + 11'h001;
    end

    // ------------------------------------------------------------------------
    // Storage and wiper
    // ------------------------------------------------------------------------

    // The array holds no reset; its contents model nonvolatile cells.
    always_ff @(posedge link_clk)
    begin
        if (wr_mem)
            mem[ptr] <= shift;
    end

    // Wiper loads on the falling edge that closes the data byte's last bit;
    // at the end of power-up it takes the stored initial value.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            wiper_position_register <= WIPER_RESET;
        else if (wr_top)
            wiper_position_register <= shift[6:0];
        else if (rdy_s && !rdy_d)
            wiper_position_register <= stored_initial_wiper_value;
    end

    // The stored value stands in for a nonvolatile cell and keeps the wiper's
    // reset value until first written.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            stored_initial_wiper_value <= WIPER_RESET;
        else if (wr_top && !vol_only)
            stored_initial_wiper_value <= shift[6:0];
    end

    // Volatile-only select; writes to it never start a write cycle.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            vol_only <= 1'b0;
        else if (wr_ctrl)
            vol_only <= shift[VOL_ONLY_BIT];
    end

    // ------------------------------------------------------------------------
    // Nonvolatile write launch
    // ------------------------------------------------------------------------

    // Any nonvolatile byte in the frame arms the cycle; only the stop fires
    // it, but the byte is stored at once and the arm outlives a repeated start until a later stop.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            nv_pending <= 1'b0;
        else if (wr_nv)
            nv_pending <= 1'b1;
        else if (stop_det && !nv_busy)
            nv_pending <= 1'b0;
    end

    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            req_tgl <= 1'b0;
        else if (stop_det && !nv_busy && nv_pending)
            req_tgl <= !req_tgl;
    end

    assign ctl.nv_req_tgl = req_tgl;

    // Busy is shown for power-up and for each write cycle.
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            nv_write_busy <= 1'b1;
        else
            nv_write_busy <= nv_busy;
    end

endmodule : ims_i2c_slave

`default_nettype wire

// *** verif/ims_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Pin-level checks of the serial slave
// ----------------------------------------------------------------------------
module ims_checker
(
    // Reset and link clock.
    input  wire logic       nrst,
    input  wire logic       link_clk,
    // Pins and status.
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       sda_o,
    input  wire logic       sda_oe,
    input  wire logic [6:0] wiper_position_register,
    input  wire logic       nv_write_busy
);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!nrst);
    logic started;
    // A start must be seen before the slave may ever pull the line.
    always_ff @(posedge link_clk or negedge nrst)
        if (!nrst)
            started <= 1'b0;
        else if (scl_i && $fell(sda_i))
            started <= 1'b1;
    logic [3:0] oe_pulses;
    // An acknowledge runs straight into a read byte of leading zeros, so the
    // line may stay pulled for nine clock pulses, never for a tenth.
    always_ff @(posedge link_clk or negedge nrst)
        if (!nrst)
            oe_pulses <= 4'h0;
        else if (!sda_oe)
            oe_pulses <= 4'h0;
        else if ($rose(scl_i) && (oe_pulses != 4'hf))
            oe_pulses <= oe_pulses + 4'h1;
    a_open_drain: assert property (sda_oe |-> sda_o == 1'b0) else $error("drove data high");
    a_busy_quiet: assert property (nv_write_busy |-> !sda_oe) else $error("drove while busy");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i) else $error("data moved, clock high");
    a_start_first: assert property ($rose(sda_oe) |-> started) else $error("answered before start");
    a_busy_at_stop: assert property ($rose(nv_write_busy) |-> scl_i && sda_i) else $error("busy off stop");
    a_busy_hold: assert property ($rose(nv_write_busy) |=> nv_write_busy[*8]) else $error("busy too short");
    a_wiper_on_low: assert property ($changed(wiper_position_register) |-> !scl_i || nv_write_busy
        || $past(nv_write_busy, 8)) else $error("wiper moved, clock high");
    a_ack_bounded: assert property (oe_pulses <= 4'h9) else $error("line held too long");
endmodule : ims_checker

bind ims_i2c_slave ims_checker u_chk
(
    .nrst(nrst),
    .link_clk(link_clk),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wiper_position_register(wiper_position_register),
    .nv_write_busy(nv_write_busy)
);
`default_nettype wire

// *** verif/ims_i2c_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Bus master model; phases of two system clocks
// ----------------------------------------------------------------------------
module ims_i2c_master
(
    // Pacing clock and resolved data line.
    input  wire logic clk,
    input  wire logic sda,
    // Driven lines; a low sda_m pulls data down.
    output var  logic scl,
    output var  logic sda_m
);
    // Both lines released at time zero.
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task ph;
        repeat (2) @(posedge clk);
    endtask : ph
    // Also serves as repeated start from a low clock.
    task start;
        ph();
        sda_m <= 1'b1;
        ph();
        scl <= 1'b1;
        ph();
        sda_m <= 1'b0;
        ph();
        scl <= 1'b0;
    endtask : start
    task stop;
        ph();
        sda_m <= 1'b0;
        ph();
        scl <= 1'b1;
        ph();
        sda_m <= 1'b1;
    endtask : stop
    // Eight bits then the answer bit; data moves only in the low phase.
    task xfer(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic sa);
        logic [8:0] w;
        w = {d, ma};
        for (int i = 8; i >= 0; i--)
        begin
            ph();
            sda_m <= w[i];
            ph();
            scl <= 1'b1;
            ph();
            w[i] = sda;
            scl <= 1'b0;
        end
        q = w[8:1];
        sa = w[0];
    endtask : xfer
endmodule : ims_i2c_master
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Testbench of the serial slave
// ----------------------------------------------------------------------------
module tb_top;
    import ims_pkg::*;
    localparam logic [3:0] TC = TYPE_CODE_DEF;
    logic       clk, link_clk, nrst, wp_n, scl, sda_m, sda_w, sda_o, sda_oe, busy;
    logic [6:0] wiper;
    int         err_total, n_tests, cyc;
    // Open-drain line with pull-up.
    assign sda_w = sda_m & ~(sda_oe & ~sda_o);
    ims_i2c_slave #(.TYPE_CODE(TC), .NV_CYCLES(200), .PU_CYCLES(10)) uut (.clk(clk), .nrst(nrst),
        .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .write_protect_n(wp_n), .wiper_position_register(wiper), .nv_write_busy(busy));
    ims_i2c_master m (.clk(clk), .sda(sda_w), .scl(scl), .sda_m(sda_m));
    // Clocks; the link clock has its own phase.
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    // Guard against a hang.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            end_sim();
        end
    end
    task chk1(input logic g, input logic e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk1
    task chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk8
    task op(input logic [7:0] d, input logic e);
        logic [7:0] q;
        logic       a;
        m.xfer(d, 1'b1, q, a);
        chk1(a, e);
    endtask : op
    task hdr(input logic [10:0] ad);
        m.start();
        op({TC, ad[10:8], 1'b0}, 1'b0);
        op(ad[7:0], 1'b0);
    endtask : hdr
    task rd2(input logic [10:0] ad, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] q;
        logic       a;
        hdr(ad);
        m.start();
        op({TC, ad[10:8], 1'b1}, 1'b0);
        m.xfer(8'hff, 1'b0, q, a);
        chk8(q, e0);
        m.xfer(8'hff, 1'b1, q, a);
        chk8(q, e1);
        m.stop();
    endtask : rd2
    task wait_idle;
        for (int i = 0; i < 3000 && busy !== 1'b0; i++)
            @(posedge clk);
        chk1(busy, 1'b0);
    endtask : wait_idle
    task t_bad_id;
        m.start();
        op({~TC, 4'h0}, 1'b1);
        m.stop();
    endtask : t_bad_id
    // Four bytes end exactly on the page's last byte, as a master must keep to.
    task t_page;
        hdr(11'h12c);
        op(8'ha5, 1'b0);
        op(8'h3c, 1'b0);
        op(8'h5a, 1'b0);
        op(8'hc3, 1'b0);
        m.stop();
        repeat (4) @(posedge clk);
        chk1(busy, 1'b1);
        m.start();
        op({TC, 4'h0}, 1'b1);
        m.stop();
        wait_idle();
        rd2(11'h12c, 8'ha5, 8'h3c);
        rd2(11'h12e, 8'h5a, 8'hc3);
    endtask : t_page
    task t_wiper(input logic [7:0] sel, input logic [7:0] val, input logic nv);
        hdr(11'h7fe);
        op(sel, 1'b0);
        op(val, 1'b0);
        chk8({1'b0, wiper}, val);
        m.stop();
        repeat (4) @(posedge clk);
        chk1(busy, nv);
        wait_idle();
        rd2(11'h7fe, sel, val);
    endtask : t_wiper
    // A refused byte must leave the stored byte as it was.
    task t_protect;
        @(posedge clk);
        wp_n <= 1'b0;
        hdr(11'h12c);
        op(8'h99, 1'b1);
        m.stop();
        repeat (4) @(posedge clk);
        chk1(busy, 1'b0);
        wp_n <= 1'b1;
        rd2(11'h12c, 8'ha5, 8'h3c);
    endtask : t_protect
    task end_sim;
        $display("Counts: %0d mismatches, %0d comparisons", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    // Main sequence.
    initial
    begin
        nrst = 1'b0;
        wp_n = 1'b1;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        wait_idle();
        chk1(sda_oe, 1'b0);
        t_bad_id();
        t_page();
        t_wiper(8'h80, 8'h15, 1'b0);
        t_wiper(8'h00, 8'h22, 1'b1);
        t_protect();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
